// File: hw/rcn_pkg.sv
`default_nettype none
package rcn_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned SEG_NUM  = 23;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] ADDR_STATUS_CFG   = 12'h232;
  localparam logic [11:0] ADDR_POWER_DOWN   = 12'h233;
  localparam logic [11:0] ADDR_COMMIT       = 12'h234;
  localparam logic [11:0] ADDR_SEG_FIRST    = 12'ha00;
  localparam logic [11:0] ADDR_SEG_LAST     = 12'ha16;
  localparam logic [11:0] ADDR_NVM_XFER     = 12'hb00;
  localparam logic [11:0] ADDR_NVM_ERROR    = 12'hb01;
  localparam logic [11:0] ADDR_NVM_CTRL_ONE = 12'hb02;
  localparam logic [11:0] ADDR_NVM_CTRL_TWO = 12'hb03;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned BIT_INPUT_LOOP_PD = 2;
  localparam int unsigned BIT_SYNTH_LOOP_PD = 1;
  localparam int unsigned BIT_DIST_PD       = 0;
  localparam int unsigned BIT_STATUS_PIN_ZERO_XFER  = 4;
  localparam int unsigned BIT_COMMIT        = 0;
  localparam int unsigned BIT_WRITE_ENABLE  = 0;
  localparam int unsigned BIT_SOFT_RELOAD   = 1;
  localparam int unsigned BIT_STORE         = 0;
  localparam logic [7:0]  RST_POWER_DOWN    = 8'h07;
  localparam logic [7:0]  RST_STATUS_CFG    = 8'h00;

  // ************************************************************
  // Segment list encoding
  // ************************************************************
  // A count byte 0x00..0x7f is followed by address high nibble and low byte.
  localparam logic [7:0]  SEG_OP_COMMIT     = 8'h80;
  localparam logic [7:0]  SEG_OP_END        = 8'hff;
  localparam logic [7:0]  SEG_DEF_COUNT     = 8'h02;
  localparam logic [7:0]  SEG_DEF_ADDR_HI   = 8'h02;
  localparam logic [7:0]  SEG_DEF_ADDR_LO   = 8'h32;

  typedef enum logic [2:0] {
    RCN_IDLE  = 3'b000,
    RCN_FETCH = 3'b001,
    RCN_MOVE  = 3'b010,
    RCN_LAND  = 3'b011,
    RCN_SUM   = 3'b100,
    RCN_CHECK = 3'b101
  } rcn_state_e;

  function automatic logic [7:0] seg_default(input int unsigned i);
    case (i)
      0:       seg_default = SEG_DEF_COUNT;
      1:       seg_default = SEG_DEF_ADDR_HI;
      2:       seg_default = SEG_DEF_ADDR_LO;
      3:       seg_default = SEG_OP_COMMIT;
      default: seg_default = SEG_OP_END;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: hw/rcn_nvm_mem.sv
`default_nettype none
module rcn_nvm_mem #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];

  // The array has no reset, as a real nonvolatile store keeps its content.
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule
`default_nettype wire

// File: hw/rcn_top.sv
`default_nettype none
module rcn_top
  import rcn_pkg::*;
#(
  parameter int unsigned NVM_AW = 6
) (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       ce_i,
  input  wire logic [rcn_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_rd_i,
  output logic      [7:0]                 reg_rdata_o,
  input  wire logic                       nvm_sel_n_i,
  input  wire logic                       status_other_i,
  output logic                            status_pin_zero_o,
  output logic                            input_loop_pd_o,
  output logic                            synth_loop_pd_o,
  output logic                            dist_pd_o
);
  import rcn_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  rcn_state_e               state_q, state_d;
  logic                     store_q, store_d;
  logic [7:0]               seg_q [SEG_NUM];
  logic [7:0]               seg_d [SEG_NUM];
  logic [7:0]               pd_buf_q, pd_buf_d, pd_act_q, pd_act_d;
  logic [7:0]               cfg_buf_q, cfg_buf_d, cfg_act_q, cfg_act_d;
  logic                     commit_q, commit_d;
  logic                     wen_q, wen_d;
  logic                     err_q, err_d;
  logic [4:0]               idx_q, idx_d;
  logic [6:0]               cnt_q, cnt_d;
  logic [ADDR_W-1:0]        addr_q, addr_d;
  logic [NVM_AW-1:0]        ptr_q, ptr_d;
  logic [7:0]               sum_q, sum_d;
  logic [7:0]               rdata_q, rdata_d;
  logic                     mem_we;
  logic [7:0]               mem_wdata, mem_rdata;
  logic                     wr_en;
  logic [ADDR_W-1:0]        wr_a;
  logic [7:0]               wr_v;
  logic                     busy;

  function automatic logic [7:0] seg_at(input logic [4:0] i);
    seg_at = (i < 5'(SEG_NUM)) ? seg_q[i] : SEG_OP_END;
  endfunction

  function automatic logic in_seg(input logic [ADDR_W-1:0] a);
    in_seg = (a >= ADDR_SEG_FIRST) && (a <= ADDR_SEG_LAST);
  endfunction

  function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_SEG_FIRST;
    case (a)
      ADDR_STATUS_CFG:   reg_read = cfg_buf_q;
      ADDR_POWER_DOWN:   reg_read = pd_buf_q;
      ADDR_NVM_XFER:     reg_read = {7'h00, busy};
      ADDR_NVM_ERROR:    reg_read = {7'h00, err_q};
      ADDR_NVM_CTRL_ONE: reg_read = {6'h00, busy && !store_q, wen_q};
      ADDR_NVM_CTRL_TWO: reg_read = {7'h00, busy && store_q};
      default:           reg_read = in_seg(a) ? seg_q[off[4:0]] : 8'h00;
    endcase
  endfunction

  assign busy = (state_q != RCN_IDLE);

  rcn_nvm_mem #(
    .AW (NVM_AW),
    .DW (8)
  ) u_nvm (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .we_i     (mem_we),
    .addr_i   (ptr_q),
    .wdata_i  (mem_wdata),
    .rdata_o  (mem_rdata)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [ADDR_W-1:0] off;
    logic [7:0]        seg_cur;
    logic [7:0]        seg_hi;
    logic [7:0]        seg_lo;
    off       = '0;
    seg_cur   = seg_at(idx_q);
    seg_hi    = seg_at(idx_q + 5'd1);
    seg_lo    = seg_at(idx_q + 5'd2);
    state_d   = state_q;
    store_d   = store_q;
    seg_d     = seg_q;
    pd_buf_d  = pd_buf_q;
    cfg_buf_d = cfg_buf_q;
    pd_act_d  = pd_act_q;
    cfg_act_d = cfg_act_q;
    commit_d  = 1'b0;
    wen_d     = wen_q;
    err_d     = err_q;
    idx_d     = idx_q;
    cnt_d     = cnt_q;
    addr_d    = addr_q;
    ptr_d     = ptr_q;
    sum_d     = sum_q;
    mem_we    = 1'b0;
    mem_wdata = 8'h00;
    wr_en     = 1'b0;
    wr_a      = reg_addr_i;
    wr_v      = reg_wdata_i;
    rdata_d   = reg_rd_i ? reg_read(reg_addr_i) : rdata_q;

    if (commit_q) begin
      pd_act_d  = pd_buf_q;
      cfg_act_d = cfg_buf_q;
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_COMMIT: commit_d = reg_wdata_i[BIT_COMMIT];
        ADDR_NVM_CTRL_ONE: begin
          wen_d = reg_wdata_i[BIT_WRITE_ENABLE];
          if (reg_wdata_i[BIT_SOFT_RELOAD] && !nvm_sel_n_i && !busy) begin
            state_d   = RCN_FETCH;
            store_d   = 1'b0;
            pd_buf_d  = RST_POWER_DOWN;
            cfg_buf_d = RST_STATUS_CFG;
            err_d     = 1'b0;
          end
        end
        ADDR_NVM_CTRL_TWO: begin
          if (reg_wdata_i[BIT_STORE] && !busy) begin
            state_d = RCN_FETCH;
            store_d = 1'b1;
          end
        end
        default: wr_en = 1'b1;
      endcase
      if (state_d == RCN_FETCH && !busy) begin
        idx_d = '0;
        ptr_d = '0;
        sum_d = 8'h00;
      end
    end

    case (state_q)
      RCN_IDLE: begin
      end
      RCN_FETCH: begin
        if (seg_cur == SEG_OP_END) begin
          state_d = RCN_SUM;
        end else if (seg_cur == SEG_OP_COMMIT) begin
          // A host commit in the same cycle must not be lost to the opcode.
          commit_d = commit_d || !store_q;
          idx_d    = idx_q + 5'd1;
        end else begin
          cnt_d   = seg_cur[6:0];
          addr_d  = {seg_hi[3:0], seg_lo};
          idx_d   = idx_q + 5'd3;
          state_d = (seg_cur[6:0] == 7'd0) ? RCN_FETCH : RCN_MOVE;
        end
      end
      RCN_MOVE: begin
        if (store_q) begin
          mem_we    = wen_q;
          mem_wdata = reg_read(addr_q);
          sum_d     = sum_q ^ reg_read(addr_q);
          ptr_d     = ptr_q + 1'b1;
          addr_d    = addr_q + 1'b1;
          cnt_d     = cnt_q - 7'd1;
          state_d   = (cnt_q == 7'd1) ? RCN_FETCH : RCN_MOVE;
        end else begin
          state_d = RCN_LAND;
        end
      end
      RCN_LAND: begin
        wr_en   = 1'b1;
        wr_a    = addr_q;
        wr_v    = mem_rdata;
        sum_d   = sum_q ^ mem_rdata;
        ptr_d   = ptr_q + 1'b1;
        addr_d  = addr_q + 1'b1;
        cnt_d   = cnt_q - 7'd1;
        state_d = (cnt_q == 7'd1) ? RCN_FETCH : RCN_MOVE;
      end
      RCN_SUM: begin
        mem_we    = store_q && wen_q;
        mem_wdata = sum_q;
        state_d   = store_q ? RCN_IDLE : RCN_CHECK;
      end
      RCN_CHECK: begin
        err_d   = (mem_rdata != sum_q);
        state_d = RCN_IDLE;
      end
      default: state_d = RCN_IDLE;
    endcase

    // In RCN_LAND the walk owns the buffer write port, so a host write in that cycle is lost.
    if (wr_en) begin
      off = wr_a - ADDR_SEG_FIRST;
      if (wr_a == ADDR_STATUS_CFG) begin
        cfg_buf_d = wr_v;
      end else if (wr_a == ADDR_POWER_DOWN) begin
        pd_buf_d = wr_v;
      end else if (in_seg(wr_a)) begin
        seg_d[off[4:0]] = wr_v;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q   <= RCN_IDLE;
      store_q   <= 1'b0;
      for (int i = 0; i < SEG_NUM; i++) begin
        seg_q[i] <= seg_default(i);
      end
      pd_buf_q  <= RST_POWER_DOWN;
      pd_act_q  <= RST_POWER_DOWN;
      cfg_buf_q <= RST_STATUS_CFG;
      cfg_act_q <= RST_STATUS_CFG;
      commit_q  <= 1'b0;
      wen_q     <= 1'b0;
      err_q     <= 1'b0;
      idx_q     <= '0;
      cnt_q     <= '0;
      addr_q    <= '0;
      ptr_q     <= '0;
      sum_q     <= 8'h00;
      rdata_q   <= 8'h00;
    end else if (ce_i) begin
      state_q   <= state_d;
      store_q   <= store_d;
      seg_q     <= seg_d;
      pd_buf_q  <= pd_buf_d;
      pd_act_q  <= pd_act_d;
      cfg_buf_q <= cfg_buf_d;
      cfg_act_q <= cfg_act_d;
      commit_q  <= commit_d;
      wen_q     <= wen_d;
      err_q     <= err_d;
      idx_q     <= idx_d;
      cnt_q     <= cnt_d;
      addr_q    <= addr_d;
      ptr_q     <= ptr_d;
      sum_q     <= sum_d;
      rdata_q   <= rdata_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata_o       = rdata_q;
  assign input_loop_pd_o   = pd_act_q[BIT_INPUT_LOOP_PD];
  assign synth_loop_pd_o   = pd_act_q[BIT_SYNTH_LOOP_PD];
  assign dist_pd_o         = pd_act_q[BIT_DIST_PD];
  assign status_pin_zero_o = cfg_act_q[BIT_STATUS_PIN_ZERO_XFER] ? busy : status_other_i;
endmodule
`default_nettype wire

// File: verification/rcn_top_chk.sv
`default_nettype none
module rcn_top_chk
  import rcn_pkg::*;
#(
  parameter int unsigned NVM_AW = 6
) (
  input wire logic                        clk_i,
  input wire logic                        resetn_i,
  input wire logic                        ce_i,
  input wire logic [rcn_pkg::ADDR_W-1:0]  reg_addr_i,
  input wire logic                        reg_wr_i,
  input wire logic [7:0]                  reg_wdata_i,
  input wire logic                        reg_rd_i,
  input wire logic [7:0]                  reg_rdata_o,
  input wire logic                        nvm_sel_n_i,
  input wire logic                        status_other_i,
  input wire logic                        status_pin_zero_o,
  input wire logic                        input_loop_pd_o,
  input wire logic                        synth_loop_pd_o,
  input wire logic                        dist_pd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pd;
  logic [2:0] pd_buf_q;
  logic       wen_q;
  logic       rd_ok;
  logic       wr_ok;
  logic       go_commit;
  assign pd        = {input_loop_pd_o, synth_loop_pd_o, dist_pd_o};
  assign rd_ok     = ce_i & reg_rd_i;
  assign wr_ok     = ce_i & reg_wr_i;
  assign go_commit = wr_ok & (reg_addr_i == ADDR_COMMIT) & reg_wdata_i[BIT_COMMIT];
  // Shadow of the last host write to the power-down buffer.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pd_buf_q <= RST_POWER_DOWN[2:0];
    end else if (wr_ok && reg_addr_i == ADDR_POWER_DOWN) begin
      pd_buf_q <= reg_wdata_i[2:0];
    end
  end
  // Shadow of the write-enable bit as the host last wrote it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wen_q <= 1'b0;
    end else if (wr_ok && reg_addr_i == ADDR_NVM_CTRL_ONE) begin
      wen_q <= reg_wdata_i[BIT_WRITE_ENABLE];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_pd_reset;
    $rose(resetn_i) |-> pd == 3'b111;
  endproperty
  a_pd_reset: assert property (p_pd_reset) else $error("pd not set");
  property p_commit;
    go_commit |=> $stable(pd) ##1 pd == $past(pd_buf_q, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("commit copy wrong");
  property p_pd_quiet;
    wr_ok && reg_addr_i == ADDR_POWER_DOWN && !$past(go_commit) && !$past(go_commit, 2)
      |=> $stable(pd);
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("pd moved early");
  property p_commit_zero;
    rd_ok && reg_addr_i == ADDR_COMMIT |=> reg_rdata_o == 8'h00;
  endproperty
  a_commit_zero: assert property (p_commit_zero) else $error("commit reads set");
  property p_pin_reset;
    $rose(resetn_i) |-> status_pin_zero_o == status_other_i;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin source wrong");
  property p_xfer_rsvd;
    rd_ok && reg_addr_i == ADDR_NVM_XFER |=> reg_rdata_o[7:1] == 7'h00;
  endproperty
  a_xfer_rsvd: assert property (p_xfer_rsvd) else $error("xfer bits wrong");
  property p_err_rsvd;
    rd_ok && reg_addr_i == ADDR_NVM_ERROR |=> reg_rdata_o[7:1] == 7'h00;
  endproperty
  a_err_rsvd: assert property (p_err_rsvd) else $error("error bits wrong");
  property p_rd_hold;
    !rd_ok |=> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_wen_read;
    rd_ok && reg_addr_i == ADDR_NVM_CTRL_ONE |=> reg_rdata_o[0] == $past(wen_q);
  endproperty
  a_wen_read: assert property (p_wen_read) else $error("write enable wrong");
endmodule
bind rcn_top rcn_top_chk #(.NVM_AW(NVM_AW)) u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .nvm_sel_n_i(nvm_sel_n_i), .status_other_i(status_other_i),
  .status_pin_zero_o(status_pin_zero_o), .input_loop_pd_o(input_loop_pd_o),
  .synth_loop_pd_o(synth_loop_pd_o), .dist_pd_o(dist_pd_o));
`default_nettype wire

// File: verification/rcn_host.sv
`default_nettype none
module rcn_host (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  output var  logic [11:0] addr_o,
  output var  logic        wr_o,
  output var  logic [7:0]  wdata_o,
  output var  logic        rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o  = 12'h000;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
    rd_o    = 1'b0;
  end
  // Released lines flip so a stale address or data never looks valid.
  task automatic idle();
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    idle();
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    addr_o = a;
    rd_o   = 1'b1;
    @(posedge clk_i);
    #1;
    d = rdata_i;
    idle();
  endtask
endmodule
`default_nettype wire

// File: verification/register_commit_and_nvm_control_test.sv
`default_nettype none
module register_commit_and_nvm_control_test;
  import rcn_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        resetn_i;
  logic        ce_i;
  logic [11:0] addr;
  logic        wr;
  logic [7:0]  wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic        sel_n;
  logic        other;
  logic        pin;
  logic [2:0]  pd;
  int          err_total;
  int          n_tests;
  rcn_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .nvm_sel_n_i(sel_n), .status_other_i(other), .status_pin_zero_o(pin),
    .input_loop_pd_o(pd[2]), .synth_loop_pd_o(pd[1]), .dist_pd_o(pd[0]));
  rcn_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd));
  always #20 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask
  // Polling is bounded so a stuck transfer ends as a mismatch, not a hang.
  task automatic wait_idle();
    logic [7:0] v;
    v = 8'h01;
    for (int i = 0; i < 60 && v !== 8'h00; i++) begin
      host.rd(ADDR_NVM_XFER, v);
    end
    chk(v, 8'h00);
  endtask
  task automatic t_reset();
    logic [7:0] want;
    rchk(ADDR_POWER_DOWN, 8'h07);
    chk({5'h00, pd}, 8'h07);
    rchk(ADDR_NVM_CTRL_ONE, 8'h00);
    rchk(ADDR_NVM_XFER, 8'h00);
    for (int i = 0; i < SEG_NUM; i++) begin
      case (i)
        0, 1:    want = 8'h02;
        2:       want = 8'h32;
        3:       want = 8'h80;
        default: want = 8'hff;
      endcase
      rchk(ADDR_SEG_FIRST + 12'(i), want);
    end
    other = 1'b1;
    @(posedge clk_i);
    #1;
    chk({7'h00, pin}, 8'h01);
  endtask
  task automatic t_commit();
    logic [7:0] vals [3] = '{8'h05, 8'h02, 8'h00};
    logic [7:0] prev = 8'h07;
    foreach (vals[i]) begin
      host.wr(ADDR_POWER_DOWN, vals[i]);
      rchk(ADDR_POWER_DOWN, vals[i]);
      chk({5'h00, pd}, prev);
      host.wr(ADDR_COMMIT, 8'h01);
      chk({5'h00, pd}, vals[i]);
      rchk(ADDR_COMMIT, 8'h00);
      prev = vals[i];
    end
    // A write offered while the clock enable is low must leave no trace.
    ce_i = 1'b0;
    host.wr(ADDR_POWER_DOWN, 8'h04);
    ce_i = 1'b1;
    rchk(ADDR_POWER_DOWN, 8'h00);
    chk({5'h00, pd}, 8'h00);
  endtask
  task automatic t_nvm();
    host.wr(ADDR_STATUS_CFG, 8'h10);
    host.wr(ADDR_POWER_DOWN, 8'h03);
    host.wr(ADDR_COMMIT, 8'h01);
    chk({7'h00, pin}, 8'h00);
    host.wr(ADDR_NVM_CTRL_ONE, 8'h01);
    rchk(ADDR_NVM_CTRL_ONE, 8'h01);
    host.wr(ADDR_NVM_CTRL_TWO, 8'h01);
    chk({7'h00, pin}, 8'h01);
    rchk(ADDR_NVM_XFER, 8'h01);
    rchk(ADDR_NVM_CTRL_TWO, 8'h01);
    wait_idle();
    rchk(ADDR_NVM_CTRL_TWO, 8'h00);
    host.wr(ADDR_POWER_DOWN, 8'h06);
    host.wr(ADDR_NVM_CTRL_ONE, 8'h00);
    host.wr(ADDR_NVM_CTRL_TWO, 8'h01);
    wait_idle();
    host.wr(ADDR_POWER_DOWN, 8'h05);
    host.wr(ADDR_COMMIT, 8'h01);
    host.wr(ADDR_NVM_CTRL_ONE, 8'h02);
    rchk(ADDR_NVM_CTRL_ONE, 8'h00);
    rchk(ADDR_POWER_DOWN, 8'h05);
    sel_n = 1'b0;
    host.wr(ADDR_NVM_CTRL_ONE, 8'h02);
    wait_idle();
    rchk(ADDR_POWER_DOWN, 8'h03);
    chk({5'h00, pd}, 8'h03);
    rchk(ADDR_STATUS_CFG, 8'h10);
    rchk(ADDR_NVM_CTRL_ONE, 8'h00);
    rchk(ADDR_NVM_ERROR, 8'h00);
    host.wr(ADDR_SEG_FIRST, 8'h01);
    host.wr(ADDR_SEG_FIRST + 12'h003, 8'hff);
    rchk(ADDR_SEG_FIRST, 8'h01);
    host.wr(ADDR_POWER_DOWN, 8'h00);
    host.wr(ADDR_COMMIT, 8'h01);
    host.wr(ADDR_NVM_CTRL_ONE, 8'h02);
    wait_idle();
    rchk(ADDR_POWER_DOWN, 8'h07);
    chk({5'h00, pd}, 8'h00);
    rchk(ADDR_NVM_ERROR, 8'h01);
  endtask
  task automatic summarize();
    $display("Comparisons: %0d, mismatches: %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    err_total++;
    $display("Watchdog expired");
    summarize();
  end
  initial begin
    err_total = 0;
    n_tests   = 0;
    clk_i     = 1'b0;
    resetn_i  = 1'b0;
    ce_i      = 1'b1;
    sel_n     = 1'b1;
    other     = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_commit();
    t_nvm();
    summarize();
  end
endmodule
`default_nettype wire
